// ==== common/hub_desc_consts.vh ====
// Constants for the hub descriptor generator: byte values, offsets, lengths,
// bus register offsets and reset values.
// Included by every design file; definitions only.
`ifndef HUB_DESC_CONSTS_VH
`define HUB_DESC_CONSTS_VH

// Descriptor select codes (internal)
`define SEL_EP          2'h0
`define SEL_IF_MTT      2'h1
`define SEL_HUB         2'h2

// Endpoint descriptor
`define EP_LEN          8'h07
`define EP_TYPE         8'h05
`define EP_ADDR         8'h81
`define EP_ATTR         8'h03
`define EP_MPS_LO       8'h01
`define EP_MPS_HI       8'h00
`define EP_INTERVAL     8'h0C

// Multi-TT interface descriptor
`define IF_LEN          8'h09
`define IF_TYPE         8'h04
`define IF_NUM          8'h00
`define IF_ALT_MTT      8'h01
`define IF_NUM_EP       8'h01
`define IF_CLASS        8'h09
`define IF_SUBCLASS     8'h00
`define IF_PROTO_MTT    8'h02
`define IF_STR_IDX      8'h00

// Hub descriptor
`define HUB_LEN         8'h09
`define HUB_TYPE        8'h29
`define HUB_TYPE_OLD    8'h00
`define HUB_PORTS_TOTAL 2'h3
`define HUB_CHAR_HI     8'h00
`define HUB_TT_THINK    2'h0
`define HUB_NO_IND      1'h0
`define HUB_FILL        8'h00

// Fixed descriptor byte offsets
`define OFS_0           3'h0
`define OFS_1           3'h1
`define OFS_2           3'h2
`define OFS_3           3'h3
`define OFS_4           3'h4
`define OFS_5           3'h5
`define OFS_6           3'h6
`define OFS_7           3'h7
`define OFS_8           4'h8

// Bus register byte addresses
`define REG_CFG         4'h0
`define REG_REQ         4'h4
`define REG_DATA        4'h8
`define REG_STAT        4'hC

// Config register fields
`define CFG_PDBP_LSB    0
`define CFG_PDSP_LSB    3
`define CFG_PMODE_BIT   6
`define CFG_PPWR_BIT    7
`define CFG_COMP_BIT    8
`define CFG_SNS_LSB     9
`define CFG_PON_LSB     16

// Reset value (internal default configuration) and bus response codes
`define CFG_RST         32'h0032_0000
`define AXI_OKAY        2'h0
`define AXI_DECERR      2'h3

`endif

// ==== verilog/hub_desc_rom.v ====
// Descriptor byte lookup: returns one byte of the selected descriptor.
// Assumes configuration inputs are stable while a byte is looked up.
`timescale 1ns/1ps
`include "hub_desc_consts.vh"

module hub_desc_rom
(
	input  wire [1:0] descSel,     // Descriptor select
	input  wire [3:0] byteIdx,     // Byte offset in descriptor
	input  wire [1:0] portCount,   // Reported port count
	input  wire [7:0] hubCharLo,   // Hub characteristics low byte
	input  wire [7:0] powerOnTime, // Power-on to power-good, 2 ms units
	output reg  [7:0] dataByte,    // Byte at offset
	output reg  [7:0] descLen      // Descriptor length
);

	always @*
	begin
		dataByte = `HUB_FILL;
		descLen  = `HUB_LEN;
		case (descSel)
		`SEL_EP:
		begin
			descLen = `EP_LEN;
			case (byteIdx)
			{1'b0, `OFS_0}: dataByte = `EP_LEN;
			{1'b0, `OFS_1}: dataByte = `EP_TYPE;
			{1'b0, `OFS_2}: dataByte = `EP_ADDR;
			{1'b0, `OFS_3}: dataByte = `EP_ATTR;
			{1'b0, `OFS_4}: dataByte = `EP_MPS_LO;
			{1'b0, `OFS_5}: dataByte = `EP_MPS_HI;
			{1'b0, `OFS_6}: dataByte = `EP_INTERVAL;
			default: dataByte = `HUB_FILL;
			endcase
		end
		`SEL_IF_MTT:
		begin
			descLen = `IF_LEN;
			case (byteIdx)
			{1'b0, `OFS_0}: dataByte = `IF_LEN;
			{1'b0, `OFS_1}: dataByte = `IF_TYPE;
			{1'b0, `OFS_2}: dataByte = `IF_NUM;
			{1'b0, `OFS_3}: dataByte = `IF_ALT_MTT;
			{1'b0, `OFS_4}: dataByte = `IF_NUM_EP;
			{1'b0, `OFS_5}: dataByte = `IF_CLASS;
			{1'b0, `OFS_6}: dataByte = `IF_SUBCLASS;
			{1'b0, `OFS_7}: dataByte = `IF_PROTO_MTT;
			`OFS_8: dataByte = `IF_STR_IDX;
			default: dataByte = `HUB_FILL;
			endcase
		end
		`SEL_HUB:
		begin
			descLen = `HUB_LEN;
			// Full index: offset 8 must not alias to offset 0
			case (byteIdx)
			{1'b0, `OFS_0}: dataByte = `HUB_LEN;
			{1'b0, `OFS_1}: dataByte = `HUB_TYPE;
			{1'b0, `OFS_2}: dataByte = {6'h00, portCount};
			{1'b0, `OFS_3}: dataByte = hubCharLo;
			{1'b0, `OFS_4}: dataByte = `HUB_CHAR_HI;
			{1'b0, `OFS_5}: dataByte = powerOnTime;
			default: dataByte = `HUB_FILL;
			endcase
		end
		default:
		begin
			dataByte = `HUB_FILL;
			descLen  = `HUB_FILL;
		end
		endcase
	end

endmodule // hub_desc_rom

// ==== verilog/hub_desc_cfg.v ====
// Derived configuration: port count and hub characteristics from config fields.
// Assumes fields come from a register loaded by default or by a bus write.
`timescale 1ns/1ps
`include "hub_desc_consts.vh"

module hub_desc_cfg
(
	input  wire       powerModeSelect,  // 0 bus powered, 1 self powered
	input  wire [2:0] disabledPortsBus, // Disabled ports, bus powered
	input  wire [2:0] disabledPortsSelf,// Disabled ports, self powered
	input  wire       portPowerMode,    // Port power switching mode
	input  wire       compoundDevice,   // Compound device flag
	input  wire [1:0] overcurrentSense, // Overcurrent sense mode
	output wire [1:0] portCount,        // Reported downstream ports
	output wire [7:0] hubCharLo         // Hub characteristics bits 7:0
);

	wire [2:0] disSel;

	assign disSel    = powerModeSelect ? disabledPortsSelf : disabledPortsBus;
	assign portCount = `HUB_PORTS_TOTAL - ({1'b0, disSel[0]} + {1'b0, disSel[1]}
		+ {1'b0, disSel[2]});
	assign hubCharLo = {`HUB_NO_IND, `HUB_TT_THINK, overcurrentSense, compoundDevice,
		1'b0, portPowerMode};

endmodule // hub_desc_cfg

// ==== verilog/hub_desc_gen.v ====
// Hub descriptor generator top: AXI4-Lite slave holding configuration and a
// descriptor read port; software requests a descriptor and reads bytes in order.
// Assumes one clock; bus master follows AXI4-Lite handshakes.
//
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`include "hub_desc_consts.vh"

module hub_desc_gen
(
	input  wire        mclk,          // Clock, 10 MHz
	input  wire        rst,           // Async reset, active high
	input  wire [3:0]  s_axi_awaddr,  // Write address
	input  wire        s_axi_awvalid, // Write address valid
	output reg         s_axi_awready, // Write address ready
	input  wire [31:0] s_axi_wdata,   // Write data
	input  wire [3:0]  s_axi_wstrb,   // Write strobes
	input  wire        s_axi_wvalid,  // Write data valid
	output reg         s_axi_wready,  // Write data ready
	output reg  [1:0]  s_axi_bresp,   // Write response
	output reg         s_axi_bvalid,  // Write response valid
	input  wire        s_axi_bready,  // Write response ready
	input  wire [3:0]  s_axi_araddr,  // Read address
	input  wire        s_axi_arvalid, // Read address valid
	output reg         s_axi_arready, // Read address ready
	output reg  [31:0] s_axi_rdata,   // Read data
	output reg  [1:0]  s_axi_rresp,   // Read response
	output reg         s_axi_rvalid,  // Read data valid
	input  wire        s_axi_rready   // Read data ready
);

	//--------------------------------------------------------------
	// Declarations
	//--------------------------------------------------------------
	reg  [31:0] cfg_r;
	reg  [1:0]  descSel_r;
	reg  [7:0]  reqLen_r;
	reg  [3:0]  byteIdx_r;
	reg         reqBad_r;
	reg  [3:0]  awAddr_r;
	reg  [31:0] wData_r;
	reg  [3:0]  wStrb_r;
	reg         awHave_r;
	reg         wHave_r;
	wire [1:0]  portCount;
	wire [7:0]  hubCharLo;
	wire [7:0]  romByte;
	wire [7:0]  descLen;
	wire [7:0]  effLen;
	wire        moreBytes;

	function [31:0] strbMerge;
		input [31:0] oldVal;
		input [31:0] newVal;
		input [3:0]  strb;
		integer      i;
		begin
			strbMerge = oldVal;
			for (i = 0; i < 4; i = i + 1)
				if (strb[i])
					strbMerge[i*8 +: 8] = newVal[i*8 +: 8];
		end
	endfunction

	//--------------------------------------------------------------
	// Configuration derivation and descriptor lookup
	//--------------------------------------------------------------
	hub_desc_cfg uCfg
	(
		.powerModeSelect  (cfg_r[`CFG_PMODE_BIT]),
		.disabledPortsBus (cfg_r[`CFG_PDBP_LSB +: 3]),
		.disabledPortsSelf(cfg_r[`CFG_PDSP_LSB +: 3]),
		.portPowerMode    (cfg_r[`CFG_PPWR_BIT]),
		.compoundDevice   (cfg_r[`CFG_COMP_BIT]),
		.overcurrentSense (cfg_r[`CFG_SNS_LSB +: 2]),
		.portCount        (portCount),
		.hubCharLo        (hubCharLo)
	);

	hub_desc_rom uRom
	(
		.descSel    (descSel_r),
		.byteIdx    (byteIdx_r),
		.portCount  (portCount),
		.hubCharLo  (hubCharLo),
		.powerOnTime(cfg_r[`CFG_PON_LSB +: 8]),
		.dataByte   (romByte),
		.descLen    (descLen)
	);

	// Response truncated to the smaller of requested and descriptor length
	assign effLen    = (reqLen_r < descLen) ? reqLen_r : descLen;
	assign moreBytes = !reqBad_r && ({4'h0, byteIdx_r} < effLen);

	//--------------------------------------------------------------
	// Write channel
	//--------------------------------------------------------------
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `AXI_OKAY;
			awHave_r      <= 1'b0;
			wHave_r       <= 1'b0;
			awAddr_r      <= 4'h0;
			wData_r       <= 32'h0000_0000;
			wStrb_r       <= 4'h0;
			cfg_r         <= `CFG_RST;
			descSel_r     <= `SEL_EP;
			reqLen_r      <= 8'h00;
			reqBad_r      <= 1'b1;
		end
		else
		begin
			s_axi_awready <= !awHave_r && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready  <= !wHave_r && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHave_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHave_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end
			if (awHave_r && wHave_r && !s_axi_bvalid)
			begin
				awHave_r     <= 1'b0;
				wHave_r      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `AXI_OKAY;
				case (awAddr_r)
				`REG_CFG: cfg_r <= strbMerge(cfg_r, wData_r, wStrb_r);
				`REG_REQ:
				begin
					reqLen_r <= wData_r[15:8];
					reqBad_r <= 1'b0;
					case (wData_r[7:0])
					`EP_TYPE: descSel_r <= `SEL_EP;
					`IF_TYPE: descSel_r <= `SEL_IF_MTT;
					`HUB_TYPE, `HUB_TYPE_OLD: descSel_r <= `SEL_HUB;
					default: reqBad_r <= 1'b1;
					endcase
				end
				`REG_STAT: ;
				`REG_DATA: ;
				default: s_axi_bresp <= `AXI_DECERR;
				endcase
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	//--------------------------------------------------------------
	// Read channel; a data read pops the next byte
	//--------------------------------------------------------------
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `AXI_OKAY;
			byteIdx_r     <= 4'h0;
		end
		else
		begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `AXI_OKAY;
				case (s_axi_araddr)
				`REG_CFG: s_axi_rdata <= cfg_r;
				`REG_REQ: s_axi_rdata <= {16'h0000, reqLen_r, 6'h00, descSel_r};
				`REG_DATA:
				begin
					s_axi_rdata <= {22'h000000, moreBytes, 1'b0, moreBytes ? romByte : `HUB_FILL};
					if (moreBytes)
						byteIdx_r <= byteIdx_r + 4'h1;
				end
				`REG_STAT: s_axi_rdata <= {8'h00, effLen, 4'h0, byteIdx_r, 5'h00, reqBad_r,
					portCount};
				default:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `AXI_DECERR;
				end
				endcase
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			// A new request wins over a byte pop
			if (awHave_r && wHave_r && !s_axi_bvalid && awAddr_r == `REG_REQ)
				byteIdx_r <= 4'h0;
		end
	end

endmodule // hub_desc_gen

// ==== test/hub_desc_gen_props.sv ====
// Checker for the descriptor generator's register and byte port.
// Assumes write address and write data are offered together.
`timescale 1ns/1ps

module hub_desc_gen_props
(
	input logic        mclk,          // Clock
	input logic        rst,           // Reset
	input logic [3:0]  s_axi_awaddr,  // AW addr
	input logic        s_axi_awvalid, // AW valid
	input logic [31:0] s_axi_wdata,   // W data
	input logic        s_axi_wvalid,  // W valid
	input logic        s_axi_wready,  // W ready
	input logic        s_axi_bvalid,  // B valid
	input logic        s_axi_bready,  // B ready
	input logic [3:0]  s_axi_araddr,  // AR addr
	input logic        s_axi_arvalid, // AR valid
	input logic        s_axi_arready, // AR ready
	input logic [31:0] s_axi_rdata,   // R data
	input logic [1:0]  s_axi_rresp,   // R resp
	input logic        s_axi_rvalid,  // R valid
	input logic        s_axi_rready   // R ready
);
	localparam logic [55:0] EP_BYTES = 56'h0C_00_01_03_81_05_07;
	localparam logic [71:0] IF_BYTES = 72'h00_02_00_09_01_01_00_04_09;
	logic [3:0] arAddr_r;
	logic [7:0] reqType_r;
	logic [7:0] reqLen_r;
	logic [3:0] idx_r;
	logic       beat;
	logic       hubReq;
	// ----------------
	// Request tracking
	// ----------------
	assign beat   = s_axi_rvalid && s_axi_rready && arAddr_r == 4'h8 && s_axi_rdata[9];
	assign hubReq = reqType_r == 8'h29 || reqType_r == 8'h00;
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			arAddr_r  <= 4'h0;
			reqType_r <= 8'h00;
			reqLen_r  <= 8'h00;
			idx_r     <= 4'h0;
		end
		else
		begin
			if (s_axi_arvalid && s_axi_arready)
				arAddr_r <= s_axi_araddr;
			if (s_axi_wvalid && s_axi_wready && s_axi_awvalid && s_axi_awaddr == 4'h4)
			begin
				reqType_r <= s_axi_wdata[7:0];
				reqLen_r  <= s_axi_wdata[15:8];
				idx_r     <= 4'h0;
			end
			else if (beat)
				idx_r <= idx_r + 4'h1;
		end
	end
	// ----------
	// Properties
	// ----------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	property p_ep_bytes;
		beat && reqType_r == 8'h05 |-> s_axi_rdata[7:0] == EP_BYTES[idx_r*8 +: 8];
	endproperty
	a_ep_bytes: assert property (p_ep_bytes) else $error("endpoint byte wrong");
	property p_if_bytes;
		beat && reqType_r == 8'h04 |-> s_axi_rdata[7:0] == IF_BYTES[idx_r*8 +: 8];
	endproperty
	a_if_bytes: assert property (p_if_bytes) else $error("interface byte wrong");
	property p_hub_head;
		beat && hubReq && idx_r < 4'h2 |-> s_axi_rdata[7:0] == (idx_r == 4'h0 ? 8'h09 : 8'h29);
	endproperty
	a_hub_head: assert property (p_hub_head) else $error("hub header wrong");
	property p_trunc;
		beat |-> idx_r < reqLen_r;
	endproperty
	a_trunc: assert property (p_trunc) else $error("byte past requested length");
	property p_decerr;
		s_axi_rvalid && arAddr_r[1:0] != 2'h0 |-> s_axi_rresp == 2'h3;
	endproperty
	a_decerr: assert property (p_decerr) else $error("unaligned read not refused");
	property p_ar_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_ar_answer: assert property (p_ar_answer) else $error("read answer late");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	c_ep: cover property (beat && reqType_r == 8'h05);
	c_hub_old: cover property (beat && reqType_r == 8'h00);
	c_decerr: cover property (s_axi_rvalid && s_axi_rresp == 2'h3);
endmodule // hub_desc_gen_props

bind hub_desc_gen hub_desc_gen_props hub_desc_gen_props_inst (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ==== test/host_master_model.sv ====
// Bus master model standing for the host side of the register port.
// Assumes tasks are called from one process, one transfer at a time.
`timescale 1ns/1ps

module host_master_model
(
	input  wire        mclk,          // Clock
	output logic [3:0]  s_axi_awaddr,  // AW addr
	output logic        s_axi_awvalid, // AW valid
	input  wire        s_axi_awready, // AW ready
	output logic [31:0] s_axi_wdata,   // W data
	output logic [3:0]  s_axi_wstrb,   // W strobes
	output logic        s_axi_wvalid,  // W valid
	input  wire        s_axi_wready,  // W ready
	input  wire [1:0]  s_axi_bresp,   // B resp
	input  wire        s_axi_bvalid,  // B valid
	output logic        s_axi_bready,  // B ready
	output logic [3:0]  s_axi_araddr,  // AR addr
	output logic        s_axi_arvalid, // AR valid
	input  wire        s_axi_arready, // AR ready
	input  wire [31:0] s_axi_rdata,   // R data
	input  wire [1:0]  s_axi_rresp,   // R resp
	input  wire        s_axi_rvalid,  // R valid
	output logic        s_axi_rready   // R ready
);
	initial
	begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
	end
	// Released payload is inverted so stale values never pass
	task automatic axiWr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] resp);
		@(posedge mclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do
		begin
			@(posedge mclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		s_axi_awaddr <= ~a;
		s_axi_wdata  <= ~d;
	endtask
	task automatic axiRd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
		@(posedge mclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do
		begin
			@(posedge mclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		d = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		s_axi_araddr <= ~a;
	endtask
endmodule // host_master_model

// ==== test/hub_descriptor_generator_bench.sv ====
// Testbench for the descriptor generator, driven through the master model.
// Assumes the block's register map and bus timing as handed over.
`timescale 1ns/1ps

module hub_descriptor_generator_bench;
	logic        mclk;
	logic        rst;
	wire  [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
	wire  [31:0] s_axi_wdata, s_axi_rdata;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	wire         s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int          badCount;
	int          checked;
	int          cycles;
	localparam logic [71:0] EP_BYTES = 72'h00_0C_00_01_03_81_05_07;
	localparam logic [71:0] IF_BYTES = 72'h00_02_00_09_01_01_00_04_09;
	logic [31:0] cfgTab [0:3] = '{32'h0032_0485, 32'h00FF_034D, 32'h0001_07F8, 32'h0000_0038};

	hub_desc_gen hub_desc_gen_inst (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	host_master_model host_master_model_inst (.mclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			badCount++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", checked, badCount);
		if (badCount == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [1:0] resp;
		host_master_model_inst.axiWr(a, d, resp);
		check({30'h0, resp}, 32'h0);
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		logic [1:0] resp;
		host_master_model_inst.axiRd(a, d, resp);
		check({30'h0, resp}, 32'h0);
	endtask
	// Request a descriptor, read n bytes, then expect the end marker
	task automatic fetch(input logic [7:0] typ, input logic [7:0] len, input logic [71:0] exp, input int n);
		logic [31:0] d;
		wr(4'h4, {16'h0, len, typ});
		for (int i = 0; i <= n; i++)
		begin
			rd(4'h8, d);
			check(d & 32'h0000_02FF, (i < n) ? {22'h0, 2'h2, exp[i*8 +: 8]} : 32'h0);
		end
	endtask
	task automatic testDefaults;
		logic [31:0] d;
		logic [1:0]  resp;
		rd(4'h0, d);
		check(d, 32'h0032_0000);
		rd(4'h8, d);
		check(d & 32'h0000_02FF, 32'h0);
		host_master_model_inst.axiRd(4'h2, d, resp);
		check({30'h0, resp}, 32'h3);
	endtask
	task automatic testEndpoint;
		logic [31:0] d;
		fetch(8'h05, 8'hFF, EP_BYTES, 7);
		rd(4'h4, d);
		check(d, 32'h0000_FF00);
		fetch(8'h05, 8'h03, EP_BYTES, 3);
	endtask
	task automatic testInterface;
		fetch(8'h04, 8'h09, IF_BYTES, 9);
	endtask
	task automatic testHub;
		logic [31:0] c;
		logic [31:0] d;
		logic [1:0]  ports;
		logic [7:0]  charLo;
		logic [71:0] hubExp;
		for (int i = 0; i < 4; i++)
		begin
			c = cfgTab[i];
			ports = 2'h3 - 2'(c[6] ? $countones(c[5:3]) : $countones(c[2:0]));
			charLo = {3'h0, c[10:9], c[8], 1'h0, c[7]};
			hubExp = {24'h0, c[23:16], 8'h00, charLo, 6'h0, ports, 16'h2909};
			wr(4'h0, c);
			fetch(i[0] ? 8'h00 : 8'h29, 8'hFF, hubExp, 9);
			rd(4'hC, d);
			check({30'h0, d[1:0]}, {30'h0, ports});
		end
	endtask
	task automatic testBadType;
		logic [31:0] d;
		logic [1:0]  resp;
		wr(4'h4, 32'h0000_FF03);
		rd(4'h8, d);
		check(d & 32'h0000_02FF, 32'h0);
		rd(4'hC, d);
		check({31'h0, d[2]}, 32'h1);
		host_master_model_inst.axiWr(4'h2, 32'h0000_0000, resp);
		check({30'h0, resp}, 32'h3);
	endtask
	// Mid-run reset restores the default configuration
	task automatic testReset;
		logic [31:0] d;
		wr(4'h0, 32'h0000_0047);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		rd(4'h0, d);
		check(d, 32'h0032_0000);
		rd(4'h8, d);
		check(d & 32'h0000_02FF, 32'h0);
	endtask

	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			badCount++;
			close_out;
		end
	end
	initial
	begin
		rst = 1'b1;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		testDefaults;
		testEndpoint;
		testInterface;
		testHub;
		testBadType;
		testReset;
		close_out;
	end
endmodule // hub_descriptor_generator_bench
